// ==== hw/mdc_defs.svh ====
// Timing counts and axis count for the motor drive control logic
`ifndef MDC_DEFS_SVH
`define MDC_DEFS_SVH

`define MDC_CLK_PERIOD_NS 10
`define MDC_ANALOG_BLANK_NS 300
`define MDC_ANALOG_BLANK_CYC ((`MDC_ANALOG_BLANK_NS + `MDC_CLK_PERIOD_NS - 1) / `MDC_CLK_PERIOD_NS)
`define MDC_DIG_BLANK_OSC_ON 3
`define MDC_DIG_BLANK_OSC_OFF 0
`define MDC_MODE_CAPTURE_CNT 2
`define MDC_NUM_AXES 4

`endif

// ==== hw/mdc_pkg.sv ====
// Types shared by the motor drive control logic
package mdc_pkg;

  typedef enum logic [2:0] {
    MDC_MODE_STANDBY = 3'b000,
    MDC_MODE_TEST = 3'b001,
    MDC_MODE_DC_S2_STEP_S = 3'b010,
    MDC_MODE_DC_L_STEP_S = 3'b011,
    MDC_MODE_DC_S4 = 3'b100,
    MDC_MODE_STEP_L = 3'b101,
    MDC_MODE_DC_L2 = 3'b110,
    MDC_MODE_STEP_S2 = 3'b111
  } mdc_mode_t;

  typedef enum logic [1:0] {
    MDC_KIND_OFF = 2'b00,
    MDC_KIND_STEP = 2'b01,
    MDC_KIND_DC_L = 2'b10,
    MDC_KIND_DC_S = 2'b11
  } mdc_kind_t;

  // One half-bridge pair: levels and enables; enable low is high impedance
  typedef struct packed {
    logic pos;
    logic neg;
    logic pos_oe;
    logic neg_oe;
  } mdc_bridge_t;

  // Per-axis control pins from the motor controller
  typedef struct packed {
    logic drive_input_one;
    logic drive_input_two;
    logic pwm_brake;
  } mdc_axis_ctl_t;

endpackage

// ==== hw/mdc_top.sv ====
// Mode decode, bridge mapping, blanking and protection for a motor driver with four half-bridge pairs
`timescale 1ns/1ps
`include "mdc_defs.svh"

module mdc_top #(
  parameter int NUM_AXES = `MDC_NUM_AXES,
  parameter int ANALOG_BLANK_CYC = `MDC_ANALOG_BLANK_CYC,
  parameter int DIG_BLANK_OSC = `MDC_DIG_BLANK_OSC_ON
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [2:0] mode_sel_in,
  input wire mdc_pkg::mdc_axis_ctl_t [3:0] axis_ctl_in,
  input wire logic [1:0] digital_blank_select_in,
  input wire logic [3:0] current_comp_in,
  input wire logic chopper_osc_pin_in,
  input wire logic thermal_trip_in,
  input wire logic overcurrent_trip_in,
  input wire logic logic_supply_ok_flag_in,
  input wire logic motor_supply_ok_flag_in,
  output mdc_pkg::mdc_bridge_t [3:0] bridge_out,
  output logic [3:0] current_limit_out,
  output logic [3:0] blank_active_out,
  output logic standby_out,
  output logic fault_latched_out,
  output mdc_pkg::mdc_mode_t drive_mode_out
);

  localparam int SYNC_W = 26;
  localparam mdc_pkg::mdc_bridge_t BRIDGE_FLOAT = '{pos: 1'b0, neg: 1'b0, pos_oe: 1'b0,
                                                     neg_oe: 1'b0};

  // Axis role in each drive mode
  function automatic mdc_pkg::mdc_kind_t kind_of(input mdc_pkg::mdc_mode_t mode,
                                                 input logic [1:0] idx);
    mdc_pkg::mdc_kind_t k;
    k = mdc_pkg::MDC_KIND_OFF;
    case (mode)
      mdc_pkg::MDC_MODE_STEP_S2: k = mdc_pkg::MDC_KIND_STEP;
      mdc_pkg::MDC_MODE_STEP_L: k = mdc_pkg::MDC_KIND_STEP;
      mdc_pkg::MDC_MODE_DC_L2: k = mdc_pkg::MDC_KIND_DC_L;
      mdc_pkg::MDC_MODE_DC_S4: k = mdc_pkg::MDC_KIND_DC_S;
      mdc_pkg::MDC_MODE_DC_L_STEP_S: begin
        k = idx[1] ? mdc_pkg::MDC_KIND_STEP : mdc_pkg::MDC_KIND_DC_L;
      end
      mdc_pkg::MDC_MODE_DC_S2_STEP_S: begin
        k = idx[1] ? mdc_pkg::MDC_KIND_STEP : mdc_pkg::MDC_KIND_DC_S;
      end
      default: k = mdc_pkg::MDC_KIND_OFF;
    endcase
    return k;
  endfunction

  // Which control set feeds an axis; combination pairs share the lower one
  function automatic logic [1:0] src_of(input mdc_pkg::mdc_mode_t mode, input logic [1:0] idx);
    logic [1:0] s;
    s = idx;
    case (mode)
      mdc_pkg::MDC_MODE_DC_L2: s = {idx[1], 1'b0};
      mdc_pkg::MDC_MODE_STEP_L: s = {idx[1], 1'b0};
      mdc_pkg::MDC_MODE_DC_L_STEP_S: s = idx[1] ? idx : 2'h0;
      default: s = idx;
    endcase
    return s;
  endfunction

  // Bridge state from one control set for a given axis role
  function automatic mdc_pkg::mdc_bridge_t drive_of(input mdc_pkg::mdc_kind_t kind,
                                                    input mdc_pkg::mdc_axis_ctl_t ctl);
    mdc_pkg::mdc_bridge_t b;
    logic brake_n;
    b = BRIDGE_FLOAT;
    brake_n = 1'b1;
    case (kind)
      mdc_pkg::MDC_KIND_STEP: begin
        // Direction and on/off only; PWM brake input has no effect here
        if (ctl.drive_input_two) begin
          b = '{pos: ctl.drive_input_one, neg: ~ctl.drive_input_one, pos_oe: 1'b1,
                neg_oe: 1'b1};
        end
      end
      mdc_pkg::MDC_KIND_DC_L, mdc_pkg::MDC_KIND_DC_S: begin
        brake_n = (kind == mdc_pkg::MDC_KIND_DC_L) ? ctl.pwm_brake : 1'b1;
        if (ctl.drive_input_one && ctl.drive_input_two) begin
          b = '{pos: 1'b0, neg: 1'b0, pos_oe: 1'b1, neg_oe: 1'b1};
        end else if (!ctl.drive_input_one && ctl.drive_input_two) begin
          b = '{pos: 1'b0, neg: brake_n, pos_oe: 1'b1, neg_oe: 1'b1};
        end else if (ctl.drive_input_one && !ctl.drive_input_two) begin
          b = '{pos: brake_n, neg: 1'b0, pos_oe: 1'b1, neg_oe: 1'b1};
        end else begin
          b = BRIDGE_FLOAT;
        end
      end
      default: b = BRIDGE_FLOAT;
    endcase
    return b;
  endfunction

  // Two-stage synchroniser for every pin input except clk_in and rst_b_in
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;

  assign pin_raw = {mode_sel_in, axis_ctl_in, digital_blank_select_in, current_comp_in,
                    chopper_osc_pin_in, thermal_trip_in, overcurrent_trip_in,
                    logic_supply_ok_flag_in, motor_supply_ok_flag_in};

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  logic [2:0] mode_s;
  mdc_pkg::mdc_axis_ctl_t [3:0] ctl_s;
  logic [1:0] dblank_s;
  logic [3:0] comp_s;
  logic osc_s;
  logic therm_s;
  logic oc_s;
  logic vcc_ok_s;
  logic vm_ok_s;

  assign {mode_s, ctl_s, dblank_s, comp_s, osc_s, therm_s, oc_s, vcc_ok_s, vm_ok_s} = sync2_q;

  // Mode pins are taken once, after the synchroniser has filled
  logic [1:0] start_cnt_q;
  mdc_pkg::mdc_mode_t mode_q;
  logic mode_valid_q;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      start_cnt_q <= 2'h0;
      mode_q <= mdc_pkg::MDC_MODE_STANDBY;
      mode_valid_q <= 1'b0;
    end else if (!mode_valid_q) begin
      start_cnt_q <= start_cnt_q + 2'h1;
      if (start_cnt_q == 2'(`MDC_MODE_CAPTURE_CNT)) begin
        mode_q <= mdc_pkg::mdc_mode_t'(mode_s);
        mode_valid_q <= 1'b1;
      end
    end
  end

  // Oscillator edge for digital blanking
  logic osc_prev_q;
  logic osc_rise;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_s;
    end
  end

  assign osc_rise = osc_s & ~osc_prev_q;

  // Axis roles and mode-wide status
  mdc_pkg::mdc_kind_t [3:0] kind;
  logic has_dc;
  logic mode_off;

  always_comb begin
    has_dc = 1'b0;
    for (int i = 0; i < NUM_AXES; i++) begin
      kind[i] = mode_valid_q ? kind_of(mode_q, 2'(i)) : mdc_pkg::MDC_KIND_OFF;
      if (kind[i] == mdc_pkg::MDC_KIND_DC_L || kind[i] == mdc_pkg::MDC_KIND_DC_S) begin
        has_dc = 1'b1;
      end
    end
  end

  assign mode_off = !mode_valid_q || mode_q == mdc_pkg::MDC_MODE_STANDBY ||
                    mode_q == mdc_pkg::MDC_MODE_TEST;

  // Blanking state per axis
  logic [5:0] ana_cnt_q [4];
  logic [1:0] dig_cnt_q [4];
  logic [3:0] blank;

  always_comb begin
    for (int i = 0; i < NUM_AXES; i++) begin
      blank[i] = (ana_cnt_q[i] != 6'h00) || (dig_cnt_q[i] != 2'h0);
    end
  end

  // Protection: undervoltage is a level, a trip latches until power-on reset
  logic fault_q;
  logic oc_seen;
  logic standby;

  // Over-current during the spike after switching is expected; in modes with a DC axis it is masked outside blanking
  assign oc_seen = oc_s & (has_dc ? (|blank) : 1'b1);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      fault_q <= 1'b0;
    end else if (therm_s || oc_seen) begin
      fault_q <= 1'b1;
    end
  end

  assign standby = !vcc_ok_s || !vm_ok_s || fault_q || mode_off;

  // Next bridge states
  mdc_pkg::mdc_bridge_t [3:0] bridge_d;
  mdc_pkg::mdc_bridge_t [3:0] bridge_q;

  always_comb begin
    for (int i = 0; i < NUM_AXES; i++) begin
      if (standby) begin
        bridge_d[i] = BRIDGE_FLOAT;
      end else begin
        bridge_d[i] = drive_of(kind[i], ctl_s[src_of(mode_q, 2'(i))]);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      bridge_q <= '{default: BRIDGE_FLOAT};
    end else begin
      bridge_q <= bridge_d;
    end
  end

  // A new driving state restarts blanking for that axis
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < NUM_AXES; i++) begin
        ana_cnt_q[i] <= 6'h00;
        dig_cnt_q[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < NUM_AXES; i++) begin
        if (bridge_d[i] != bridge_q[i] && bridge_d[i].pos_oe) begin
          ana_cnt_q[i] <= 6'(ANALOG_BLANK_CYC);
          if (kind[i] != mdc_pkg::MDC_KIND_STEP && dblank_s[i/2]) begin
            dig_cnt_q[i] <= 2'(DIG_BLANK_OSC);
          end else begin
            dig_cnt_q[i] <= 2'(`MDC_DIG_BLANK_OSC_OFF);
          end
        end else if (ana_cnt_q[i] != 6'h00) begin
          ana_cnt_q[i] <= ana_cnt_q[i] - 6'h01;
        end else if (dig_cnt_q[i] != 2'h0 && osc_rise) begin
          // Digital part follows the analog part, counted in oscillator periods
          dig_cnt_q[i] <= dig_cnt_q[i] - 2'h1;
        end
      end
    end
  end

  // Current limit request, comparator ignored during blanking
  logic [3:0] limit_q;
  logic [3:0] blank_q;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      limit_q <= 4'h0;
      blank_q <= 4'h0;
    end else begin
      for (int i = 0; i < NUM_AXES; i++) begin
        limit_q[i] <= comp_s[i] & ~blank[i] & bridge_q[i].pos_oe;
        blank_q[i] <= blank[i];
      end
    end
  end

  // Status outputs
  logic standby_q;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      standby_q <= 1'b1;
    end else begin
      standby_q <= standby;
    end
  end

  assign bridge_out = bridge_q;
  assign current_limit_out = limit_q;
  assign blank_active_out = blank_q;
  assign standby_out = standby_q;
  assign fault_latched_out = fault_q;
  assign drive_mode_out = mode_q;

endmodule

// ==== dv/mdc_top_properties.sv ====
// Port-level checker for the motor drive control logic
`timescale 1ns/1ps
module mdc_top_properties #(
  parameter int NUM_AXES = 4,
  parameter int ANALOG_BLANK_CYC = 30,
  parameter int DIG_BLANK_OSC = 3
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [2:0] mode_sel_in,
  input wire mdc_pkg::mdc_axis_ctl_t [3:0] axis_ctl_in,
  input wire logic [1:0] digital_blank_select_in,
  input wire logic [3:0] current_comp_in,
  input wire logic chopper_osc_pin_in,
  input wire logic thermal_trip_in,
  input wire logic overcurrent_trip_in,
  input wire logic logic_supply_ok_flag_in,
  input wire logic motor_supply_ok_flag_in,
  input wire mdc_pkg::mdc_bridge_t [3:0] bridge_out,
  input wire logic [3:0] current_limit_out,
  input wire logic [3:0] blank_active_out,
  input wire logic standby_out,
  input wire logic fault_latched_out,
  input wire mdc_pkg::mdc_mode_t drive_mode_out
);
  logic [3:0] oe;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      oe[i] = bridge_out[i].pos_oe | bridge_out[i].neg_oe;
    end
  end
  float_in_standby_a: assert property (
    standby_out && $past(standby_out) |-> oe == 4'h0) else $error("bridge driven in standby");
  fault_sticky_a: assert property (
    fault_latched_out |=> fault_latched_out) else $error("fault latch released");
  trip_latch_a: assert property (
    thermal_trip_in |-> ##[1:4] fault_latched_out) else $error("thermal trip not latched");
  supply_standby_a: assert property (
    !(logic_supply_ok_flag_in && motor_supply_ok_flag_in) |-> ##[1:4] standby_out)
    else $error("supply loss without standby");
  mode_static_a: assert property (
    drive_mode_out != mdc_pkg::MDC_MODE_STANDBY |=> $stable(drive_mode_out))
    else $error("captured mode changed");
  test_float_a: assert property (
    drive_mode_out inside {mdc_pkg::MDC_MODE_TEST, mdc_pkg::MDC_MODE_STANDBY} |-> oe == 4'h0)
    else $error("bridge driven in test or standby mode");
  no_step_brake_a: assert property (
    drive_mode_out == mdc_pkg::MDC_MODE_STEP_S2 |->
    !(oe[0] && !bridge_out[0].pos && !bridge_out[0].neg)) else $error("brake in stepping mode");
  limit_mask_a: assert property (
    (current_limit_out & blank_active_out) == 4'h0) else $error("limit seen while blanking");
  step_blank_a: assert property (
    $rose(blank_active_out[0]) && drive_mode_out == mdc_pkg::MDC_MODE_STEP_S2 |->
    ##29 blank_active_out[0] ##1 !blank_active_out[0]) else $error("stepping blank length");
  dc_blank_a: assert property (
    $rose(blank_active_out[0]) && drive_mode_out == mdc_pkg::MDC_MODE_DC_S4 &&
    digital_blank_select_in[0] |-> ##30 blank_active_out[0] ##[16:30] !blank_active_out[0])
    else $error("digital blank length");
endmodule
bind mdc_top mdc_top_properties #(.NUM_AXES(NUM_AXES), .ANALOG_BLANK_CYC(ANALOG_BLANK_CYC),
  .DIG_BLANK_OSC(DIG_BLANK_OSC)) mdc_top_properties_i (.*);

// ==== dv/mdc_ctl_model.sv ====
// Behavioural motor controller driving the per-axis control pins
`timescale 1ns/1ps
module mdc_ctl_model (
  input wire logic clk_in,
  input wire logic power_good_in,
  input wire mdc_pkg::mdc_axis_ctl_t [3:0] cmd_in,
  output mdc_pkg::mdc_axis_ctl_t [3:0] axis_ctl_out = '0
);
  // Pins move on the falling edge so the device never samples a changing level
  always @(negedge clk_in) begin
    for (int i = 0; i < 4; i++) begin
      // One update per pin per edge; on/off held low while power is not good
      axis_ctl_out[i] <= '{drive_input_one: cmd_in[i].drive_input_one,
                           drive_input_two: cmd_in[i].drive_input_two & power_good_in,
                           pwm_brake: cmd_in[i].pwm_brake};
    end
  end
endmodule

// ==== dv/mdc_top_tb_top.sv ====
// Self-checking bench for the motor drive control logic
`timescale 1ns/1ps
module mdc_top_tb_top;
  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] c0;
    logic [2:0] c1;
    logic [15:0] br;
  } mdc_row_t;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [2:0] mode_sel = 3'h0;
  mdc_pkg::mdc_axis_ctl_t [3:0] cmd = '0;
  mdc_pkg::mdc_axis_ctl_t [3:0] axis_ctl;
  logic power_good = 1'b0;
  logic [1:0] dblank = 2'h0;
  logic [3:0] comp = 4'h0;
  logic osc = 1'b0;
  logic therm = 1'b0;
  logic ovc = 1'b0;
  logic vcc_ok = 1'b1;
  logic vm_ok = 1'b1;
  mdc_pkg::mdc_bridge_t [3:0] bridge;
  logic [3:0] limit;
  logic [3:0] blank;
  logic standby;
  logic fault;
  mdc_pkg::mdc_mode_t mode;
  int err_count = 0;
  int samples_checked = 0;
  int l0;
  int l2;
  logic [15:0] sb;
  mdc_row_t rows [15] = '{{3'h7, 3'h6, 3'h3, 16'h7b7b}, {3'h7, 3'h4, 3'h2, 16'h7070},
    {3'h6, 3'h3, 3'h5, 16'h7777}, {3'h6, 3'h2, 3'h5, 16'h3333}, {3'h6, 3'h7, 3'h5, 16'h3333},
    {3'h6, 3'h4, 3'h5, 16'h3333}, {3'h6, 3'h1, 3'h5, 16'h0000}, {3'h6, 3'h5, 3'h0, 16'hbbbb},
    {3'h5, 3'h2, 3'h4, 16'h7777}, {3'h4, 3'h6, 3'h4, 16'hb3b3}, {3'h4, 3'h2, 3'h0, 16'h0707},
    {3'h3, 3'h2, 3'h6, 16'hb733}, {3'h2, 3'h4, 3'h3, 16'h707b}, {3'h1, 3'h6, 3'h6, 16'h0000},
    {3'h0, 3'h6, 3'h3, 16'h0000}};
  mdc_ctl_model mdc_ctl_model_i (.clk_in(clk_in), .power_good_in(power_good), .cmd_in(cmd),
    .axis_ctl_out(axis_ctl));
  mdc_top mdc_top_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .mode_sel_in(mode_sel),
    .axis_ctl_in(axis_ctl), .digital_blank_select_in(dblank), .current_comp_in(comp),
    .chopper_osc_pin_in(osc), .thermal_trip_in(therm), .overcurrent_trip_in(ovc),
    .logic_supply_ok_flag_in(vcc_ok), .motor_supply_ok_flag_in(vm_ok), .bridge_out(bridge),
    .current_limit_out(limit), .blank_active_out(blank), .standby_out(standby),
    .fault_latched_out(fault), .drive_mode_out(mode));
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic go(input int c);
    repeat (c) @(negedge clk_in);
  endtask
  // Levels of a floating half-bridge mean nothing, so only its enables are compared
  function automatic logic [15:0] seen_br();
    logic [15:0] v;
    v = bridge;
    for (int i = 0; i < 4; i++) begin
      if (v[4*i+:2] == 2'b00) begin
        v[4*i+2+:2] = 2'b00;
      end
    end
    return v;
  endfunction
  task automatic rst(input logic [2:0] m);
    rst_b_in = 1'b0;
    power_good = 1'b0;
    mode_sel = m;
    go(12);
    rst_b_in = 1'b1;
    power_good = 1'b1;
  endtask
  // Counts blanking cycles of axes A and C over a fixed window after a drive change
  task automatic blen();
    l0 = 0;
    l2 = 0;
    for (int k = 0; k < 120; k++) begin
      go(1);
      l0 += int'(blank[0] === 1'b1);
      l2 += int'(blank[2] === 1'b1);
      if (k == 10) begin
        chk("limit", {12'h0, limit}, 16'h0);
      end
    end
  endtask
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  always begin
    go(4);
    osc = ~osc;
  end
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
  initial begin
    foreach (rows[r]) begin
      rst(rows[r].mode);
      cmd = {rows[r].c1, rows[r].c0, rows[r].c1, rows[r].c0};
      go(10);
      sb = seen_br();
      chk("bridge", sb, rows[r].br);
      chk("bridge_cd", {8'h0, sb[15:8]}, {8'h0, rows[r].br[15:8]});
      chk("mode", {13'h0, mode}, {13'h0, rows[r].mode});
      chk("standby", {15'h0, standby}, {15'h0, rows[r].mode[2:1] == 2'b00});
    end
    rst(3'h7);
    cmd = {4{3'h7}};
    go(10);
    mode_sel = 3'h0;
    vcc_ok = 1'b0;
    go(8);
    chk("mode", {13'h0, mode}, 16'h7);
    chk("bridge", seen_br(), 16'h0);
    vcc_ok = 1'b1;
    vm_ok = 1'b0;
    go(8);
    chk("standby", {15'h0, standby}, 16'h1);
    vm_ok = 1'b1;
    go(8);
    chk("bridge", seen_br(), 16'hbbbb);
    dblank = 2'h3;
    comp = 4'hf;
    rst(3'h7);
    cmd = {4{3'h2}};
    blen();
    chk("blank", 16'(l0 * 256 + l2), 16'h1e1e);
    chk("limit", {12'h0, limit}, 16'hf);
    dblank = 2'h1;
    rst(3'h4);
    cmd = {4{3'h2}};
    blen();
    chk("blank", {15'h0, l0 > 46 && l0 < 60}, 16'h1);
    chk("blank", 16'(l2), 16'd30);
    ovc = 1'b1;
    go(4);
    ovc = 1'b0;
    go(6);
    chk("fault", {15'h0, fault}, 16'h0);
    cmd = {4{3'h4}};
    ovc = 1'b1;
    go(12);
    ovc = 1'b0;
    go(10);
    chk("fault", {15'h0, fault}, 16'h1);
    chk("bridge", seen_br(), 16'h0);
    rst(3'h7);
    chk("fault", {15'h0, fault}, 16'h0);
    therm = 1'b1;
    go(2);
    therm = 1'b0;
    go(8);
    chk("fault", {15'h0, fault}, 16'h1);
    end_sim();
  end
endmodule
